// >>> blc_pkg.sv
// boot loader command port: shared constants, states and types
// assumes a byte-wide register port with 8-bit addresses, one clock
// Contract
// - boot registers visible only in bootloader application
// - command location: write command, read status
// - payload buffer of up to 128 bytes
// - checksum is inverted eight-bit sum
// - remap command maps RAM, then resets system
// - remap executes at once when accepted
// - invalid RAM program needs host hardware reset
// - remap sent with zero length, checksum 0xEE
// - download prepare initialises download hardware
// - download prepare carries one seed byte
// - host sets pointer before memory write
// - memory write stores payload, pointer advances
// - write length at most 128, checksum follows; the length field here is 7 bits, so at most 127
// - set pointer carries low then high byte
package blc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] BLC_APP_BOOT = 8'h80; // bootloader app id
   localparam logic [7:0] BLC_ADR_CMD = 8'h08; // command / status
   localparam logic [7:0] BLC_ADR_LEN = 8'h09; // payload length
   localparam logic [7:0] BLC_ADR_DATA = 8'h0a; // first payload byte
   localparam logic [7:0] BLC_ADR_DATA_END = 8'h8a; // end of payload window, aliases byte 0
   localparam logic [7:0] BLC_ADR_CSUM = 8'h8b; // checksum
   localparam logic [7:0] BLC_ZERO = 8'h00; // reset / success value
   localparam logic [7:0] BLC_ONES = 8'hff; // checksum inversion mask
   localparam int BLC_LEN_W = 7; // length field width
   localparam int BLC_BUF_DEPTH = 128; // payload bytes
   // ------------------------------------------------------------
   // commands and status codes
   // ------------------------------------------------------------
   localparam logic [7:0] BLC_CMD_REMAP = 8'h11; // remap_and_restart
   localparam logic [7:0] BLC_CMD_DL_INIT = 8'h14; // download preparation
   localparam logic [7:0] BLC_CMD_WRITE = 8'h41; // memory write
   localparam logic [7:0] BLC_CMD_SETPTR = 8'h43; // set pointer
   localparam logic [7:0] BLC_ST_CSUM_ERR = 8'h01; // bad checksum
   localparam logic [7:0] BLC_ST_CMD_ERR = 8'h02; // unknown command
   localparam logic [7:0] BLC_ST_LEN_ERR = 8'h03; // wrong length
   localparam logic [7:0] BLC_ST_BUSY = 8'h04; // command running
   // device sequencer states, gray coded along the path
   typedef enum logic [1:0] {
      BLC_IDLE = 2'b00,
      BLC_SUM = 2'b01,
      BLC_EXEC = 2'b11,
      BLC_COPY = 2'b10
   } blc_state_t;
   // host sequencer states
   typedef enum logic [2:0] {
      BLC_H_IDLE = 3'b000,
      BLC_H_CMD = 3'b001,
      BLC_H_LEN = 3'b011,
      BLC_H_DATA = 3'b010,
      BLC_H_CSUM = 3'b110,
      BLC_H_WAIT = 3'b111,
      BLC_H_POLL = 3'b101
   } blc_hstate_t;
endpackage : blc_pkg

// >>> blc_if.sv
// boot loader command port: register bus between host and device
// assumes one shared clock; accesses are single-cycle strobes
`timescale 1ns/10ps
interface blc_if;
   logic wr_en; // host write strobe, one cycle
   logic rd_en; // host read strobe, one cycle
   logic [7:0] addr; // register address
   logic [7:0] wdata; // write data
   logic [7:0] rdata; // read data, valid cycle after rd_en
   logic rvalid; // read data valid pulse
   // documented device side
   modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
   // host side
   modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface : blc_if

// >>> blc_host.sv
// boot loader command port: host end, sends one framed command
// assumes the user holds req_cmd/len/data until done, data by index
`timescale 1ns/10ps
module blc_host
   import blc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   blc_if.host bus,
   input wire logic req, // start a command, one-cycle pulse
   input wire logic [7:0] req_cmd, // command code
   input wire logic [6:0] req_len, // payload length
   output logic [6:0] data_idx, // payload index being sent
   input wire logic [7:0] data_byte, // payload byte at data_idx
   output logic busy, // frame in progress
   output logic done, // one-cycle completion pulse
   output logic [7:0] status // last status read back
);
   blc_hstate_t st; // sequencer state
   logic [7:0] sum; // running checksum
   logic [7:0] cmd_q; // latched command
   logic [6:0] len_q; // latched length
   // ------------------------------------------------------------
   // frame sequencer
   // ------------------------------------------------------------
   wire last_data = (data_idx == len_q - 7'd1);
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= BLC_H_IDLE;
         sum <= BLC_ZERO;
         cmd_q <= BLC_ZERO;
         len_q <= '0;
         data_idx <= '0;
         status <= BLC_ZERO;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st)
            BLC_H_IDLE: begin
               if (req) begin
                  cmd_q <= req_cmd;
                  len_q <= req_len;
                  st <= BLC_H_CMD;
               end
            end
            BLC_H_CMD: begin
               sum <= cmd_q;
               st <= BLC_H_LEN;
            end
            BLC_H_LEN: begin
               sum <= sum + {1'b0, len_q};
               data_idx <= '0;
               st <= (len_q == '0) ? BLC_H_CSUM : BLC_H_DATA;
            end
            BLC_H_DATA: begin
               sum <= sum + data_byte;
               data_idx <= data_idx + 7'd1;
               if (last_data) st <= BLC_H_CSUM;
            end
            BLC_H_CSUM: st <= BLC_H_WAIT;
            BLC_H_WAIT: st <= BLC_H_POLL;
            BLC_H_POLL: begin
               if (bus.rvalid && bus.rdata != BLC_ST_BUSY) begin
                  status <= bus.rdata;
                  done <= 1'b1;
                  st <= BLC_H_IDLE;
               end else if (bus.rvalid) begin
                  st <= BLC_H_WAIT;
               end
            end
            default: st <= BLC_H_IDLE;
         endcase
      end
   end
   // ------------------------------------------------------------
   // bus drive (combinational handshake)
   // ------------------------------------------------------------
   wire is_wr = (st == BLC_H_CMD) || (st == BLC_H_LEN) || (st == BLC_H_DATA) || (st == BLC_H_CSUM);
   always_comb begin
      bus.addr = BLC_ADR_CMD;
      bus.wdata = cmd_q;
      case (st)
         BLC_H_LEN: begin
            bus.addr = BLC_ADR_LEN;
            bus.wdata = {1'b0, len_q};
         end
         BLC_H_DATA: begin
            bus.addr = BLC_ADR_DATA + {1'b0, data_idx};
            bus.wdata = data_byte;
         end
         BLC_H_CSUM: begin
            bus.addr = BLC_ADR_CSUM;
            bus.wdata = sum ^ BLC_ONES;
         end
         default: begin
            bus.addr = BLC_ADR_CMD;
            bus.wdata = cmd_q;
         end
      endcase
   end
   assign bus.wr_en = is_wr;
   assign bus.rd_en = (st == BLC_H_WAIT);
   assign busy = (st != BLC_H_IDLE);
endmodule : blc_host

// >>> blc_dev.sv
// boot loader command port: device end with payload buffer and RAM
// assumes host writes command, length, payload, then checksum
`timescale 1ns/10ps
module blc_dev
   import blc_pkg::*;
#(
   parameter int RAM_AW = 12 // program RAM address width
)(
   input wire logic clk,
   input wire logic srst,
   blc_if.dev bus,
   input wire logic [7:0] app_id, // running application id
   output logic remap, // RAM mapped to zero, level
   output logic sys_reset, // full system reset request, pulse
   output logic dl_init, // download hardware init pulse
   output logic [7:0] dl_seed, // seed for download hardware
   output logic [15:0] ram_ptr // RAM read/write pointer
);
   logic [7:0] cmd; // latched command code
   logic [7:0] stat; // status returned on read
   logic [BLC_LEN_W-1:0] len; // payload length
   logic [7:0] csum; // checksum register
   logic [7:0] buf_mem [BLC_BUF_DEPTH]; // payload buffer
   logic [7:0] ram [2**RAM_AW]; // program RAM
   logic [7:0] sum; // running sum for checking
   logic [BLC_LEN_W:0] idx; // walk index
   blc_state_t st; // sequencer state
   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire boot_on = (app_id == BLC_APP_BOOT);
   wire in_data = (bus.addr >= BLC_ADR_DATA) && (bus.addr <= BLC_ADR_DATA_END);
   wire [6:0] data_off = 7'(bus.addr - BLC_ADR_DATA);
   wire wr_ok = bus.wr_en && boot_on && (st == BLC_IDLE);
   wire wr_cmd = wr_ok && (bus.addr == BLC_ADR_CMD);
   wire wr_len = wr_ok && (bus.addr == BLC_ADR_LEN);
   wire wr_dat = wr_ok && in_data;
   wire wr_csum = wr_ok && (bus.addr == BLC_ADR_CSUM);
   wire [6:0] walk = idx[6:0];
   wire walk_end = (idx == {1'b0, len});
   wire csum_good = ((sum ^ BLC_ONES) == csum);
   // length a command must carry, or the checksum-only check
   function automatic logic len_ok(input logic [7:0] c, input logic [6:0] l);
      case (c)
         BLC_CMD_REMAP: len_ok = (l == 7'd0);
         BLC_CMD_DL_INIT: len_ok = (l == 7'd1);
         BLC_CMD_SETPTR: len_ok = (l == 7'd2);
         default: len_ok = 1'b1;
      endcase
   endfunction : len_ok
   wire cmd_known = (cmd == BLC_CMD_REMAP) || (cmd == BLC_CMD_DL_INIT) || (cmd == BLC_CMD_WRITE)
      || (cmd == BLC_CMD_SETPTR);
   // ------------------------------------------------------------
   // payload buffer writes
   // ------------------------------------------------------------
   // buffer clears on reset so reads after reset return zero
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < BLC_BUF_DEPTH; i++) buf_mem[i] <= BLC_ZERO;
      end else if (wr_dat) begin
         buf_mem[data_off] <= bus.wdata;
      end
   end
   // ------------------------------------------------------------
   // read path, one cycle latency
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         bus.rdata <= BLC_ZERO;
         bus.rvalid <= 1'b0;
      end else begin
         bus.rvalid <= bus.rd_en;
         if (!boot_on) bus.rdata <= BLC_ZERO;
         else if (bus.addr == BLC_ADR_CMD) bus.rdata <= stat;
         else if (bus.addr == BLC_ADR_LEN) bus.rdata <= {1'b0, len};
         else if (in_data) bus.rdata <= buf_mem[data_off];
         else if (bus.addr == BLC_ADR_CSUM) bus.rdata <= csum;
         else bus.rdata <= BLC_ZERO;
      end
   end
   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd <= BLC_ZERO;
         stat <= BLC_ZERO;
         len <= '0;
         csum <= BLC_ZERO;
         sum <= BLC_ZERO;
         idx <= '0;
         st <= BLC_IDLE;
         remap <= 1'b0;
         sys_reset <= 1'b0;
         dl_init <= 1'b0;
         dl_seed <= BLC_ZERO;
         ram_ptr <= '0;
      end else begin
         sys_reset <= 1'b0;
         dl_init <= 1'b0;
         if (wr_cmd) cmd <= bus.wdata;
         if (wr_len) len <= bus.wdata[BLC_LEN_W-1:0];
         case (st)
            BLC_IDLE: begin
               if (wr_csum) begin
                  csum <= bus.wdata;
                  sum <= cmd + {1'b0, len};
                  idx <= '0;
                  stat <= BLC_ST_BUSY;
                  st <= BLC_SUM;
               end
            end
            BLC_SUM: begin
               if (walk_end) st <= BLC_EXEC;
               else begin
                  sum <= sum + buf_mem[walk];
                  idx <= idx + 8'd1;
               end
            end
            BLC_EXEC: begin
               idx <= '0;
               st <= BLC_IDLE;
               if (!csum_good) stat <= BLC_ST_CSUM_ERR;
               else if (!cmd_known) stat <= BLC_ST_CMD_ERR;
               else if (!len_ok(cmd, len)) stat <= BLC_ST_LEN_ERR;
               else begin
                  stat <= BLC_ZERO;
                  case (cmd)
                     BLC_CMD_REMAP: begin
                        remap <= 1'b1;
                        sys_reset <= 1'b1;
                     end
                     BLC_CMD_DL_INIT: begin
                        dl_init <= 1'b1;
                        dl_seed <= buf_mem[0];
                     end
                     BLC_CMD_SETPTR: ram_ptr <= {buf_mem[1], buf_mem[0]};
                     BLC_CMD_WRITE: begin
                        stat <= BLC_ST_BUSY;
                        st <= (len == '0) ? BLC_IDLE : BLC_COPY;
                        if (len == '0) stat <= BLC_ZERO;
                     end
                     default: stat <= BLC_ST_CMD_ERR;
                  endcase
               end
            end
            BLC_COPY: begin
               ram[ram_ptr[RAM_AW-1:0]] <= buf_mem[walk];
               ram_ptr <= ram_ptr + 16'd1;
               idx <= idx + 8'd1;
               if (idx == {1'b0, len} - 8'd1) begin
                  stat <= BLC_ZERO;
                  st <= BLC_IDLE;
               end
            end
            default: st <= BLC_IDLE;
         endcase
      end
   end
endmodule : blc_dev

// >>> blc_sva.sv
// boot loader command port: checker for the host to device link
// assumes it stands beside the interface, all inputs tied by name
`timescale 1ns/10ps
module blc_sva
   import blc_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   logic [7:0] run_sum; // sum of the frame so far
   // ------------------------------------------------------------
   // frame sum tracker
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         run_sum <= BLC_ZERO;
      end else if (wr_en && addr == BLC_ADR_CMD) begin
         run_sum <= wdata; // a command restarts the sum
      end else if (wr_en && addr != BLC_ADR_CSUM) begin
         run_sum <= run_sum + wdata;
      end
   end
   // ------------------------------------------------------------
   // bus properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   chk_rd_answer: assert property (rd_en |=> rvalid)
      else $error("read not answered next cycle");
   chk_no_stray: assert property (!rd_en |=> !rvalid)
      else $error("read valid without a read");
   chk_strobe_excl: assert property (!(wr_en && rd_en))
      else $error("read and write strobes together");
   chk_len_field: assert property (wr_en && addr == BLC_ADR_LEN |-> !wdata[7])
      else $error("length wider than seven bits");
   chk_len_after_cmd: assert property (wr_en && addr == BLC_ADR_CMD |=> wr_en && addr == BLC_ADR_LEN)
      else $error("length write does not follow command");
   chk_write_range: assert property (wr_en |-> addr inside {[BLC_ADR_CMD:BLC_ADR_CSUM]})
      else $error("write outside the boot registers");
   chk_csum_value: assert property (wr_en && addr == BLC_ADR_CSUM |-> wdata == (run_sum ^ BLC_ONES))
      else $error("checksum byte wrong");
   chk_poll_after: assert property (wr_en && addr == BLC_ADR_CSUM |=> rd_en && addr == BLC_ADR_CMD)
      else $error("status not read after checksum");
   chk_busy_repoll: assert property (rvalid && rdata == BLC_ST_BUSY |-> ##[1:4] (rd_en && addr == BLC_ADR_CMD))
      else $error("busy status not polled again");
endmodule : blc_sva

// >>> blc_tb.sv
// boot loader command port: testbench, host and device back to back
// assumes a second device on a spare bus driven by hand for faults
`timescale 1ns/10ps
`define CHK(got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module tb
   import blc_pkg::*;
;
   logic clk, srst, req, busy, done, remap, sys_reset, dl_init, remap_q; // controls
   logic [7:0] req_cmd, app_id, data_byte, status, dl_seed, rd_b; // bytes
   logic [6:0] req_len, data_idx; // length and index
   logic [15:0] ram_ptr, ram_ptr_b; // pointers of both devices
   logic [7:0] pay [128]; // payload table
   int miscompares, checks_done, rst_cnt, dl_cnt, n; // counters
   blc_if bus();
   blc_if bus2();
   assign data_byte = pay[data_idx]; // payload served by index
   blc_host i_blc_host (.clk(clk), .srst(srst), .bus(bus), .req(req), .req_cmd(req_cmd), .req_len(req_len),
      .data_idx(data_idx), .data_byte(data_byte), .busy(busy), .done(done), .status(status));
   blc_dev #(.RAM_AW(12)) i_blc_dev (.clk(clk), .srst(srst), .bus(bus), .app_id(app_id), .remap(remap),
      .sys_reset(sys_reset), .dl_init(dl_init), .dl_seed(dl_seed), .ram_ptr(ram_ptr));
   blc_dev #(.RAM_AW(12)) i_blc_dev_2 (.clk(clk), .srst(srst), .bus(bus2), .app_id(8'h80), .remap(),
      .sys_reset(), .dl_init(), .dl_seed(), .ram_ptr(ram_ptr_b));
   blc_sva i_blc_sva (.clk(clk), .srst(srst), .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
      .wdata(bus.wdata), .rdata(bus.rdata), .rvalid(bus.rvalid));
   // ------------------------------------------------------------
   // clock, pulse monitor, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // counts pulses on the falling edge, where the flops have settled
   always @(negedge clk) begin
      if (sys_reset === 1'b1) rst_cnt++;
      if (dl_init === 1'b1) dl_cnt++;
      if (remap === 1'b1 && remap_q !== 1'b1) `CHK(sys_reset, 1'b1)
      remap_q = remap;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic give_verdict;
      if (miscompares == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   // one framed command through the host end
   task automatic send(input logic [7:0] c, input logic [6:0] l, input logic [7:0] st);
      int k;
      @(posedge clk);
      #1 req = 1'b1;
      req_cmd = c;
      req_len = l;
      @(posedge clk);
      #1 req = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 2000) begin
         @(posedge clk);
         #1 k++;
      end
      `CHK(status, st)
      `CHK(busy, 1'b0)
   endtask : send
   // raw write on the spare bus
   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 bus2.wr_en = 1'b1;
      bus2.addr = a;
      bus2.wdata = d;
      @(posedge clk);
      #1 bus2.wr_en = 1'b0;
   endtask : bw
   // raw read on the spare bus, answer lands in rd_b
   task automatic br(input logic [7:0] a);
      @(posedge clk);
      #1 bus2.rd_en = 1'b1;
      bus2.addr = a;
      @(posedge clk);
      #1 bus2.rd_en = 1'b0;
      `CHK(bus2.rvalid, 1'b1)
      rd_b = bus2.rdata;
   endtask : br
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {req, req_cmd, req_len, bus2.wr_en, bus2.rd_en, bus2.addr, bus2.wdata} = '0;
      app_id = BLC_APP_BOOT;
      remap_q = 1'b0;
      for (int i = 0; i < 128; i++) pay[i] = 8'(i * 3 + 1);
      srst = 1'b1;
      repeat (6) @(posedge clk);
      #1 srst = 1'b0;
      `CHK(ram_ptr, 16'h0000)
      `CHK(remap, 1'b0)
      br(BLC_ADR_LEN);
      `CHK(rd_b, BLC_ZERO)
      br(BLC_ADR_DATA);
      `CHK(rd_b, BLC_ZERO)
      br(8'h00);
      `CHK(rd_b, BLC_ZERO)
      pay[0] = 8'hf0;
      pay[1] = 8'h0f;
      send(BLC_CMD_SETPTR, 7'd2, BLC_ZERO);
      `CHK(ram_ptr, 16'h0ff0)
      send(BLC_CMD_WRITE, 7'd5, BLC_ZERO);
      `CHK(ram_ptr, 16'h0ff5)
      `CHK(i_blc_dev.ram[12'hff4], 8'h0d)
      send(BLC_CMD_WRITE, 7'd0, BLC_ZERO);
      `CHK(ram_ptr, 16'h0ff5)
      pay[0] = 8'h00;
      pay[1] = 8'h01;
      send(BLC_CMD_SETPTR, 7'd2, BLC_ZERO);
      send(BLC_CMD_WRITE, 7'd127, BLC_ZERO);
      `CHK(ram_ptr, 16'h017f)
      `CHK(i_blc_dev.ram[12'h17e], 8'h7b)
      pay[0] = 8'ha5;
      send(BLC_CMD_DL_INIT, 7'd1, BLC_ZERO);
      `CHK(dl_cnt, 1)
      `CHK(dl_seed, 8'ha5)
      send(BLC_CMD_REMAP, 7'd1, BLC_ST_LEN_ERR);
      send(BLC_CMD_DL_INIT, 7'd2, BLC_ST_LEN_ERR);
      send(BLC_CMD_SETPTR, 7'd1, BLC_ST_LEN_ERR);
      send(8'h22, 7'd0, BLC_ST_CMD_ERR);
      `CHK(remap, 1'b0)
      `CHK(dl_cnt, 1)
      app_id = 8'hc0;
      send(BLC_CMD_SETPTR, 7'd2, BLC_ZERO);
      `CHK(ram_ptr, 16'h017f)
      app_id = BLC_APP_BOOT;
      bw(BLC_ADR_CMD, BLC_CMD_SETPTR);
      bw(BLC_ADR_LEN, 8'h02);
      bw(BLC_ADR_DATA, 8'h01);
      bw(8'h0b, 8'h02);
      bw(BLC_ADR_CSUM, 8'h00);
      rd_b = BLC_ST_BUSY;
      n = 0;
      while (rd_b === BLC_ST_BUSY && n < 50) begin
         br(BLC_ADR_CMD);
         n++;
      end
      `CHK(rd_b, BLC_ST_CSUM_ERR)
      `CHK(ram_ptr_b, 16'h0000)
      send(BLC_CMD_REMAP, 7'd0, BLC_ZERO);
      `CHK(remap, 1'b1)
      `CHK(rst_cnt, 1)
      // host recovers by a hardware reset in mid-run
      @(posedge clk);
      #1 srst = 1'b1;
      repeat (2) @(posedge clk);
      #1 srst = 1'b0;
      `CHK(remap, 1'b0)
      send(BLC_CMD_SETPTR, 7'd2, BLC_ZERO);
      `CHK(ram_ptr, 16'h01a5)
      give_verdict();
   end
endmodule : tb
